// >>> logic/ubfl_core.sv
// Serial transceiver buffers, flags and interrupt requests behind a register port.
//
// Summary of operation
// - Buffer-empty flag is high while the transmit buffer holds nothing.
// - Buffer-empty request stays high while flag and its enable are set.
// - Writing the data register clears the buffer-empty flag.
// - Transmit-complete sets when the frame is out and no data waits.
// - Transmit-complete clears on interrupt service or on writing one.
// - Transmit-complete request rises a cycle after the flag when its enable is set.
// - With parity enabled, parity goes after data and before the stop bit.
// - Clearing transmit enable waits until shifter and buffer are empty.
// - Once really disabled, the transmit pin override is released.
// - Setting receive enable enables the receiver and takes the input pin.
// - Synchronous reception samples on the external transfer clock.
// - Bits after start shift in up to the first stop; second ignored.
// - After the first stop bit the frame moves into the receive buffer.
// - Unused high bits of short characters read as zero.
// - Ninth bit and error bits travel with each FIFO entry; data read pops.
// - Receive-complete is one, a cycle late, while unread data are buffered, and drops for the cycle after each data read.
// - Receive enable low flushes the buffer so receive-complete reads zero.
// - Receive-complete request stays high while flag and enable are set.
// - The shifter loads when idle or right after the previous last stop bit.
// - Parity is the xor of the data bits, inverted for odd.
// - Two-entry buffer; overrun when full, shifter holding, and new start.
`timescale 1ns/1ps
`default_nettype none
module ubfl_core
   import ubfl_pkg::*;
(
   input wire logic CLK_IN, // 50 MHz system clock.
   input wire logic RST_N_IN, // Synchronous reset, active low.
   input wire logic [ubfl_pkg::ADDR_W-1:0] ADDR_IN, // Register address.
   input wire logic [7:0] WR_DATA_IN, // Write data.
   input wire logic WR_EN_IN, // Write strobe.
   input wire logic RD_EN_IN, // Read strobe.
   input wire logic SERIAL_IN_PIN_IN, // Receive data pin.
   input wire logic EXT_XFER_CLK_PIN_IN, // External transfer clock pin.
   input wire logic TX_COMPLETE_ACK_IN, // Transmit-complete interrupt serviced.
   output logic [7:0] RD_DATA_OUT, // Read data, one cycle after the strobe.
   output logic SERIAL_OUT_PIN_OUT, // Transmit data level.
   output logic SERIAL_OUT_OE_OUT, // Transmit pin override active.
   output logic RX_PIN_OVERRIDE_OUT, // Receive pin taken by the receiver.
   output logic TX_BUF_EMPTY_IRQ_OUT, // Buffer-empty interrupt request.
   output logic TX_COMPLETE_IRQ_OUT, // Transmit-complete interrupt request.
   output logic RX_COMPLETE_IRQ_OUT // Receive-complete interrupt request.
);
   typedef enum logic [3:0] {
      RX_IDLE = 4'h1,
      RX_START = 4'h2,
      RX_DATA = 4'h4,
      RX_STOP = 4'h8
   } ubfl_rx_state_t;

   logic [7:0] ctrl_status_b;
   logic [7:0] fmt_reg;
   logic [7:0] baud_reg;
   ubfl_fmt_t fmt;
   logic sync_mode;
   logic rx_enable;
   logic tx_enable;

   logic wr_data;
   logic wr_csa;
   logic rd_data;

   logic [7:0] baud_cnt;
   logic tick16;
   logic [3:0] tx_os;
   logic tx_bit_en;

   logic [2:0] xck_sync;
   logic [1:0] rxd_sync;
   logic rxd;
   logic xck_rise;
   logic xck_fall;

   logic [8:0] tx_buf;
   logic tx_buf_full;
   logic tx_busy;
   logic tx_done;
   logic tx_load;
   logic tx_active;
   logic tx_line;
   logic tx_complete_flag;

   ubfl_rx_state_t rx_state;
   logic [3:0] rx_os;
   logic [3:0] rx_idx;
   logic [9:0] rx_sh;
   logic rx_sample;
   logic rx_frame_done;
   ubfl_entry_t rx_frame;
   ubfl_entry_t rx_hold;
   logic rx_hold_valid;
   logic overrun_pend;
   logic rx_start_seen;

   logic fifo_full;
   logic fifo_push;
   ubfl_entry_t fifo_push_data;
   ubfl_entry_t fifo_head;
   logic rx_complete_flag;

   logic [7:0] csa_view;
   logic [7:0] csb_view;

   assign fmt.char_size = {ctrl_status_b[B_SZ2], fmt_reg[F_SZ1], fmt_reg[F_SZ0]};
   assign fmt.parity_en = fmt_reg[F_PEN];
   assign fmt.parity_odd = fmt_reg[F_PODD];
   assign fmt.two_stop = fmt_reg[F_STOP2];
   assign sync_mode = fmt_reg[F_SYNC];
   assign rx_enable = ctrl_status_b[B_RXEN];
   assign tx_enable = ctrl_status_b[B_TXON];

   assign wr_data = WR_EN_IN && (ADDR_IN == OFS_DATA);
   assign wr_csa = WR_EN_IN && (ADDR_IN == OFS_CSA);
   assign rd_data = RD_EN_IN && (ADDR_IN == OFS_DATA);

   // Control registers; the receive ninth bit is read-only.
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         ctrl_status_b <= CSB_RESET;
         fmt_reg <= FMT_RESET;
         baud_reg <= BAUD_RESET;
      end else if (WR_EN_IN) begin
         case (ADDR_IN)
            OFS_CSB: begin
               ctrl_status_b <= WR_DATA_IN & ~(8'h01 << B_RXB8);
            end
            OFS_FMT: begin
               fmt_reg <= WR_DATA_IN;
            end
            OFS_BAUD: begin
               baud_reg <= WR_DATA_IN;
            end
            default: begin
            end
         endcase
      end
   end

   // Baud divider gives sixteen ticks per bit time.
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         baud_cnt <= 8'h00;
         tick16 <= 1'b0;
         tx_os <= 4'h0;
      end else begin
         tick16 <= (baud_cnt == baud_reg);
         baud_cnt <= (baud_cnt == baud_reg) ? 8'h00 : baud_cnt + 8'h01;
         // A load restarts the bit phase so the start bit lasts a full bit time.
         if (tx_load) begin
            tx_os <= 4'h0;
         end else if (tick16) begin
            tx_os <= tx_os + 4'h1;
         end
      end
   end

   // Pins from outside pass two flip-flops; edges use the second and third.
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         xck_sync <= 3'h0;
         rxd_sync <= 2'h3;
      end else begin
         xck_sync <= {xck_sync[1:0], EXT_XFER_CLK_PIN_IN};
         rxd_sync <= {rxd_sync[0], SERIAL_IN_PIN_IN};
      end
   end

   assign rxd = rxd_sync[1];
   assign xck_rise = xck_sync[1] && !xck_sync[2];
   assign xck_fall = !xck_sync[1] && xck_sync[2];
   assign tx_bit_en = sync_mode ? xck_fall : (tick16 && (tx_os == OS_LAST));

   // Disable takes effect only when shifter and buffer are empty.
   assign tx_active = tx_enable || tx_busy || tx_buf_full;
   // Load when idle or in the cycle the last stop bit ends.
   assign tx_load = tx_buf_full && tx_active && (!tx_busy || tx_done);

   // Buffer state, empty flag is its inverse.
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         tx_buf <= 9'h000;
         tx_buf_full <= 1'b0;
      end else if (wr_data) begin
         tx_buf <= {ctrl_status_b[B_TX9], WR_DATA_IN};
         tx_buf_full <= 1'b1;
      end else if (tx_load) begin
         tx_buf_full <= 1'b0;
      end
   end

   ubfl_tx_shift u_tx (
      .clk_in(CLK_IN),
      .rst_n_in(RST_N_IN),
      .load_in(tx_load),
      .data_in(tx_buf),
      .fmt_in(fmt),
      .bit_en_in(tx_bit_en),
      .line_out(tx_line),
      .busy_out(tx_busy),
      .done_out(tx_done)
   );

   assign SERIAL_OUT_PIN_OUT = tx_line;

   // Pin override follows the effective enable.
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         SERIAL_OUT_OE_OUT <= 1'b0;
      end else begin
         SERIAL_OUT_OE_OUT <= tx_active;
      end
   end

   // Transmit-complete: a set in the same cycle as a clear wins.
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         tx_complete_flag <= 1'b0;
      end else if (tx_done && !tx_buf_full) begin
         // Set when frame out and buffer empty.
         tx_complete_flag <= 1'b1;
      end else if (TX_COMPLETE_ACK_IN || (wr_csa && WR_DATA_IN[A_TXC])) begin
         // Clear on service or write one.
         tx_complete_flag <= 1'b0;
      end
   end

   // Receiver samples: mid-bit in async mode, rising transfer clock in sync.
   // Sync mode uses external clock.
   assign rx_sample = sync_mode ? xck_rise : (tick16 && (rx_os == OS_LAST));

   always_ff @(posedge CLK_IN) begin
      rx_start_seen <= 1'b0;
      rx_frame_done <= 1'b0;
      if (!RST_N_IN || !rx_enable) begin
         rx_state <= RX_IDLE;
         rx_os <= 4'h0;
         rx_idx <= 4'h0;
         rx_sh <= 10'h000;
         rx_start_seen <= 1'b0;
         rx_frame_done <= 1'b0;
      end else begin
         if (tick16) begin
            rx_os <= rx_os + 4'h1;
         end
         case (rx_state)
            RX_IDLE: begin
               rx_idx <= 4'h0;
               if (sync_mode ? (xck_rise && !rxd) : !rxd) begin
                  rx_state <= sync_mode ? RX_DATA : RX_START;
                  rx_start_seen <= sync_mode;
                  rx_os <= 4'h0;
               end
            end
            RX_START: begin
               if (tick16 && (rx_os == OS_MID)) begin
                  rx_state <= rxd ? RX_IDLE : RX_DATA;
                  rx_start_seen <= !rxd;
                  rx_os <= 4'h0;
               end
            end
            RX_DATA: begin
               if (rx_sample) begin
                  rx_sh[rx_idx] <= rxd;
                  rx_idx <= rx_idx + 4'h1;
                  if (rx_idx == ubfl_nbits(fmt.char_size) + {3'h0, fmt.parity_en} - 4'h1) begin
                     rx_state <= RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               // Only the first stop bit is sampled.
               if (rx_sample) begin
                  rx_frame_done <= 1'b1;
                  rx_state <= RX_IDLE;
               end
            end
            default: begin
               rx_state <= RX_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (rx_state == RX_STOP) begin
         rx_frame.overrun <= overrun_pend;
         if (rx_sample) begin
            rx_frame.frame_err <= !rxd;
         end
         rx_frame.data <= rx_sh[8:0] & ubfl_mask(fmt.char_size);
         rx_frame.parity_err <= fmt.parity_en &&
            (ubfl_parity(rx_sh[8:0], fmt.char_size, fmt.parity_odd) !=
             rx_sh[ubfl_nbits(fmt.char_size)]);
      end
   end

   // A frame that meets a full buffer waits in the shifter as rx_hold.
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN || !rx_enable) begin
         rx_hold <= '0;
         rx_hold_valid <= 1'b0;
         overrun_pend <= 1'b0;
      end else begin
         if (rx_start_seen && rx_hold_valid && fifo_full) begin
            // Waiting frame lost on new start.
            overrun_pend <= 1'b1;
            rx_hold_valid <= 1'b0;
         end else if (rx_frame_done && fifo_full) begin
            rx_hold <= rx_frame;
            rx_hold_valid <= 1'b1;
         end else if (rx_hold_valid && !fifo_full) begin
            rx_hold_valid <= 1'b0;
         end
         if (fifo_push) begin
            overrun_pend <= 1'b0;
         end
      end
   end

   // Complete frame moves into the buffer.
   assign fifo_push = (rx_hold_valid && !fifo_full) || (rx_frame_done && !fifo_full);
   assign fifo_push_data = rx_hold_valid ? rx_hold : rx_frame;

   ubfl_rx_fifo u_rx_fifo (
      .clk_in(CLK_IN),
      .rst_n_in(RST_N_IN),
      .flush_in(!rx_enable),
      .push_in(fifo_push),
      .push_data_in(fifo_push_data),
      .pop_in(rd_data && rx_complete_flag),
      .full_out(fifo_full),
      .head_out(fifo_head),
      .valid_out(rx_complete_flag)
   );

   always_comb begin
      csa_view = 8'h00;
      csa_view[A_RXC] = rx_complete_flag;
      csa_view[A_TXC] = tx_complete_flag;
      csa_view[A_UDRE] = !tx_buf_full;
      csa_view[A_FE] = fifo_head.frame_err && rx_complete_flag;
      csa_view[A_DOR] = fifo_head.overrun && rx_complete_flag;
      csa_view[A_PE] = fifo_head.parity_err && rx_complete_flag;
      csb_view = ctrl_status_b;
      csb_view[B_RXB8] = fifo_head.data[8] && rx_complete_flag;
   end

   // Read data stand in the cycle after the strobe and read zero otherwise.
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN || !RD_EN_IN) begin
         RD_DATA_OUT <= 8'h00;
      end else begin
         case (ADDR_IN)
            OFS_DATA: begin
               RD_DATA_OUT <= rx_complete_flag ? fifo_head.data[7:0] : 8'h00;
            end
            OFS_CSA: begin
               RD_DATA_OUT <= csa_view;
            end
            OFS_CSB: begin
               RD_DATA_OUT <= csb_view;
            end
            OFS_FMT: begin
               RD_DATA_OUT <= fmt_reg;
            end
            OFS_BAUD: begin
               RD_DATA_OUT <= baud_reg;
            end
            default: begin
               RD_DATA_OUT <= 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         TX_BUF_EMPTY_IRQ_OUT <= 1'b0;
         TX_COMPLETE_IRQ_OUT <= 1'b0;
         RX_COMPLETE_IRQ_OUT <= 1'b0;
         RX_PIN_OVERRIDE_OUT <= 1'b0;
      end else begin
         TX_BUF_EMPTY_IRQ_OUT <= !tx_buf_full && ctrl_status_b[B_UDRIE];
         TX_COMPLETE_IRQ_OUT <= tx_complete_flag && ctrl_status_b[B_TXCIE];
         RX_COMPLETE_IRQ_OUT <= rx_complete_flag && ctrl_status_b[B_RXCIE];
         RX_PIN_OVERRIDE_OUT <= rx_enable;
      end
   end
endmodule
`default_nettype wire

// >>> logic/ubfl_pkg.sv
// Shared constants, types and helper functions for the serial buffer and flag block.
package ubfl_pkg;
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned ADDR_W = 3;
   localparam logic [2:0] OFS_DATA = 3'h0;
   localparam logic [2:0] OFS_CSA = 3'h1;
   localparam logic [2:0] OFS_CSB = 3'h2;
   localparam logic [2:0] OFS_FMT = 3'h3;
   localparam logic [2:0] OFS_BAUD = 3'h4;
   // Bit positions in ctrl_status_a.
   localparam int unsigned A_RXC = 7;
   localparam int unsigned A_TXC = 6;
   localparam int unsigned A_UDRE = 5;
   localparam int unsigned A_FE = 4;
   localparam int unsigned A_DOR = 3;
   localparam int unsigned A_PE = 2;
   // Bit positions in ctrl_status_b.
   localparam int unsigned B_RXCIE = 7;
   localparam int unsigned B_TXCIE = 6;
   localparam int unsigned B_UDRIE = 5;
   localparam int unsigned B_RXEN = 4;
   localparam int unsigned B_TXON = 3;
   localparam int unsigned B_SZ2 = 2;
   localparam int unsigned B_RXB8 = 1;
   localparam int unsigned B_TX9 = 0;
   // Bit positions in the frame format register.
   localparam int unsigned F_SYNC = 6;
   localparam int unsigned F_PEN = 5;
   localparam int unsigned F_PODD = 4;
   localparam int unsigned F_STOP2 = 3;
   localparam int unsigned F_SZ1 = 2;
   localparam int unsigned F_SZ0 = 1;
   localparam logic [7:0] CSB_RESET = 8'h00;
   localparam logic [7:0] FMT_RESET = 8'h06;
   localparam logic [7:0] BAUD_RESET = 8'h00;
   localparam logic [2:0] SIZE_NINE = 3'h7;
   localparam logic [3:0] OS_LAST = 4'hf;
   localparam logic [3:0] OS_MID = 4'h7;
   localparam int unsigned FIFO_DEPTH = 2;

   typedef struct packed {
      logic [2:0] char_size;
      logic parity_en;
      logic parity_odd;
      logic two_stop;
   } ubfl_fmt_t;

   typedef struct packed {
      logic [8:0] data;
      logic frame_err;
      logic overrun;
      logic parity_err;
   } ubfl_entry_t;

   function automatic logic [3:0] ubfl_nbits(input logic [2:0] size);
      ubfl_nbits = (size == SIZE_NINE) ? 4'h9 : {2'h0, size[1:0]} + 4'h5;
   endfunction

   function automatic logic [8:0] ubfl_mask(input logic [2:0] size);
      ubfl_mask = 9'h1ff >> (4'h9 - ubfl_nbits(size));
   endfunction

   function automatic logic ubfl_parity(input logic [8:0] d, input logic [2:0] size,
                                        input logic odd);
      ubfl_parity = (^(d & ubfl_mask(size))) ^ odd;
   endfunction
endpackage

// >>> logic/ubfl_rx_fifo.sv
// Two-entry receive FIFO holding each character with its status bits.
`timescale 1ns/1ps
`default_nettype none
module ubfl_rx_fifo
   import ubfl_pkg::*;
(
   input wire logic clk_in, // System clock.
   input wire logic rst_n_in, // Synchronous reset, active low.
   input wire logic flush_in, // Empties the FIFO.
   input wire logic push_in, // Writes one entry.
   input wire ubfl_pkg::ubfl_entry_t push_data_in, // Entry to write.
   input wire logic pop_in, // Drops the oldest entry.
   output logic full_out, // No room left.
   output ubfl_pkg::ubfl_entry_t head_out, // Oldest entry, registered.
   output logic valid_out // Head holds unread data, registered.
);
   ubfl_entry_t mem [FIFO_DEPTH];
   logic wr_ptr;
   logic rd_ptr;
   logic [1:0] count;
   logic do_push;
   logic do_pop;

   assign do_push = push_in && (count != 2'h2);
   assign do_pop = pop_in && (count != 2'h0);
   assign full_out = (count == 2'h2);

   always_ff @(posedge clk_in) begin
      if (do_push) begin
         mem[wr_ptr] <= push_data_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in || flush_in) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count <= 2'h0;
      end else begin
         if (do_push) begin
            wr_ptr <= ~wr_ptr;
         end
         if (do_pop) begin
            rd_ptr <= ~rd_ptr;
         end
         count <= count + {1'b0, do_push} - {1'b0, do_pop};
      end
   end

   // Head and valid come from the same cycle's state so they always agree.
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || flush_in) begin
         head_out <= '0;
         valid_out <= 1'b0;
      end else begin
         head_out <= mem[rd_ptr];
         valid_out <= (count != 2'h0) && !do_pop;
      end
   end
endmodule
`default_nettype wire

// >>> logic/ubfl_tx_shift.sv
// Transmit shift register that sends one whole frame per load.
`timescale 1ns/1ps
`default_nettype none
module ubfl_tx_shift
   import ubfl_pkg::*;
(
   input wire logic clk_in, // System clock.
   input wire logic rst_n_in, // Synchronous reset, active low.
   input wire logic load_in, // Takes a new character.
   input wire logic [8:0] data_in, // Character with ninth bit.
   input wire ubfl_pkg::ubfl_fmt_t fmt_in, // Frame format.
   input wire logic bit_en_in, // One pulse per bit time.
   output logic line_out, // Serial line level.
   output logic busy_out, // Frame in progress.
   output logic done_out // Pulse after the last stop bit.
);
   logic [11:0] frame;
   logic [11:0] shreg;
   logic [3:0] left;
   logic [3:0] nb;
   logic par;

   // Data bits, then parity, then stop bits, all after the start bit.
   always_comb begin
      nb = ubfl_nbits(fmt_in.char_size);
      par = ubfl_parity(data_in, fmt_in.char_size, fmt_in.parity_odd);
      frame = 12'hfff;
      for (int i = 0; i < 9; i++) begin
         if (4'(i) < nb) begin
            frame[i] = data_in[i];
         end
      end
      if (fmt_in.parity_en) begin
         frame[nb] = par;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         shreg <= 12'hfff;
         left <= 4'h0;
         busy_out <= 1'b0;
         done_out <= 1'b0;
         line_out <= 1'b1;
      end else begin
         done_out <= 1'b0;
         if (load_in) begin
            shreg <= frame;
            left <= nb + {3'h0, fmt_in.parity_en} + {3'h0, fmt_in.two_stop} + 4'h1;
            busy_out <= 1'b1;
            line_out <= 1'b0;
         end else if (busy_out && bit_en_in) begin
            if (left == 4'h0) begin
               busy_out <= 1'b0;
               done_out <= 1'b1;
               line_out <= 1'b1;
            end else begin
               line_out <= shreg[0];
               shreg <= {1'b1, shreg[11:1]};
               left <= left - 4'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// >>> bench/ubfl_core_asserts.sv
// Port-level assertions for the serial buffer and flag block.
`timescale 1ns/1ps
`default_nettype none
module ubfl_core_asserts
   import ubfl_pkg::*;
(
   input wire logic CLK_IN, // Clock.
   input wire logic RST_N_IN, // Reset, active low.
   input wire logic [ubfl_pkg::ADDR_W-1:0] ADDR_IN, // Address.
   input wire logic [7:0] WR_DATA_IN, // Write data.
   input wire logic WR_EN_IN, // Write strobe.
   input wire logic RD_EN_IN, // Read strobe.
   input wire logic SERIAL_IN_PIN_IN, // Receive line.
   input wire logic EXT_XFER_CLK_PIN_IN, // Transfer clock.
   input wire logic TX_COMPLETE_ACK_IN, // Service pulse.
   input wire logic [7:0] RD_DATA_OUT, // Read data.
   input wire logic SERIAL_OUT_PIN_OUT, // Transmit line.
   input wire logic SERIAL_OUT_OE_OUT, // Transmit override.
   input wire logic RX_PIN_OVERRIDE_OUT, // Receive override.
   input wire logic TX_BUF_EMPTY_IRQ_OUT, // Empty request.
   input wire logic TX_COMPLETE_IRQ_OUT, // Complete request.
   input wire logic RX_COMPLETE_IRQ_OUT // Receive request.
);
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!RST_N_IN);
   sequence s_csb_wr;
      WR_EN_IN && ADDR_IN == OFS_CSB;
   endsequence
   a_rd_idle_zero: assert property (!$past(RD_EN_IN) |-> RD_DATA_OUT == 8'h00)
      else $error("read data not zero");
   a_rx_take_pin: assert property (s_csb_wr ##0 WR_DATA_IN[B_RXEN] |-> ##[1:2] RX_PIN_OVERRIDE_OUT)
      else $error("receive pin not taken");
   a_rx_off_noirq: assert property (!RX_PIN_OVERRIDE_OUT [*4] |-> !RX_COMPLETE_IRQ_OUT)
      else $error("receive request while disabled");
   a_txc_ack_clear: assert property (TX_COMPLETE_ACK_IN |-> ##2 !TX_COMPLETE_IRQ_OUT)
      else $error("complete request not cleared");
   a_txc_rise_idle: assert property ($rose(TX_COMPLETE_IRQ_OUT) |-> $past(SERIAL_OUT_PIN_OUT))
      else $error("complete request mid frame");
   a_oe_fall_idle: assert property ($fell(SERIAL_OUT_OE_OUT) |-> $past(SERIAL_OUT_PIN_OUT))
      else $error("override dropped mid frame");
   a_tx_line_idle: assert property (!SERIAL_OUT_OE_OUT |-> SERIAL_OUT_PIN_OUT)
      else $error("line low while idle");
   a_bit_min_len: assert property ($rose(SERIAL_OUT_PIN_OUT) |-> SERIAL_OUT_PIN_OUT [*8])
      else $error("high bit too short");
endmodule
`default_nettype wire

// >>> bench/ubfl_remote.sv
// Remote transceiver that sends frames and captures frames sent to it.
`timescale 1ns/1ps
`default_nettype none
module ubfl_remote (
   input wire logic clk_in, // System clock.
   input wire logic line_in, // Line from the device.
   output logic line_out, // Line to the device.
   output logic [9:0] got_out, // Bits after the last start.
   output logic xck_out // Transfer clock to the device.
);
   initial line_out = 1'b1;
   initial xck_out = 1'b0;
   task automatic send(input logic [10:0] bits, input int n);
      @(posedge clk_in);
      line_out <= 1'b0;
      repeat (16) @(posedge clk_in);
      for (int k = 0; k < n; k++) begin
         line_out <= bits[k];
         repeat (16) @(posedge clk_in);
      end
      line_out <= 1'b1;
      repeat (32) @(posedge clk_in);
   endtask
   // Synchronous frame: data change while the clock is low and stand at its rise.
   task automatic ssend(input logic [7:0] d);
      logic [9:0] f;
      f = {1'b1, d, 1'b0};
      @(posedge clk_in);
      for (int k = 0; k < 10; k++) begin
         line_out <= f[k];
         xck_out <= 1'b0;
         repeat (8) @(posedge clk_in);
         xck_out <= 1'b1;
         repeat (8) @(posedge clk_in);
      end
      xck_out <= 1'b0;
   endtask
   // Samples each bit in its middle.
   always begin
      @(negedge line_in);
      repeat (8) @(posedge clk_in);
      for (int j = 0; j < 10; j++) begin
         repeat (16) @(posedge clk_in);
         got_out[j] <= line_in;
      end
   end
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking bench for the serial buffer and flag block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
   $display("[ERR] %s expected %h seen %h", nm, e, g); end end
`define WAITC(c, n) begin for (int w = 0; w < n && (c) !== 1'b1; w++) begin \
   @(posedge clk); #1; end if ((c) !== 1'b1) begin n_fail++; finish_test(); end end
module tb_top;
   import ubfl_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdat = 8'h00;
   logic wen = 1'b0;
   logic ren = 1'b0;
   logic ack = 1'b0;
   logic [7:0] rdat;
   logic txd, oe, rxo, ie, ic, ir, rxd, xck;
   logic [9:0] got;
   int n_fail = 0;
   int n_compared = 0;
   ubfl_core dut (.CLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WR_DATA_IN(wdat),
      .WR_EN_IN(wen), .RD_EN_IN(ren), .SERIAL_IN_PIN_IN(rxd), .EXT_XFER_CLK_PIN_IN(xck),
      .TX_COMPLETE_ACK_IN(ack), .RD_DATA_OUT(rdat), .SERIAL_OUT_PIN_OUT(txd),
      .SERIAL_OUT_OE_OUT(oe), .RX_PIN_OVERRIDE_OUT(rxo), .TX_BUF_EMPTY_IRQ_OUT(ie),
      .TX_COMPLETE_IRQ_OUT(ic), .RX_COMPLETE_IRQ_OUT(ir));
   ubfl_remote rem (.clk_in(clk), .line_in(txd), .line_out(rxd), .got_out(got),
      .xck_out(xck));
   always #10 clk = ~clk;
   task automatic finish_test;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdat <= d;
      wen <= 1'b1;
      @(posedge clk);
      wen <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e, input string nm);
      @(posedge clk);
      addr <= a;
      ren <= 1'b1;
      @(posedge clk);
      ren <= 1'b0;
      #1;
      `CHK(nm, e, rdat)
   endtask
   task automatic pulse_ack;
      @(posedge clk);
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
   endtask
   task automatic t_regs;
      rd(OFS_CSB, CSB_RESET, "csb reset");
      rd(OFS_FMT, FMT_RESET, "fmt reset");
      rd(OFS_CSA, 8'h20, "csa reset");
      rd(3'h7, 8'h00, "unmapped");
      wr(OFS_CSA, 8'hdf);
      wr(OFS_CSB, 8'h02);
      rd(OFS_CSA, 8'h20, "csa fixed");
      rd(OFS_CSB, 8'h00, "csb ro");
   endtask
   task automatic t_tx;
      logic [7:0] d;
      wr(OFS_CSB, 8'h68);
      cyc(2);
      `CHK("empty irq", 1'b1, ie)
      for (int i = 0; i < 2; i++) begin
         d = i ? 8'h5a : 8'ha5;
         wr(OFS_FMT, i ? 8'h36 : 8'h26);
         wr(OFS_DATA, d);
         `WAITC(ic, 400)
         `CHK("frame", {1'b1, ^d ^ i[0], d}, got)
         if (i == 0) pulse_ack(); else wr(OFS_CSA, 8'h40);
         cyc(3);
         `CHK("txc clear", 1'b0, ic)
      end
      wr(OFS_DATA, 8'h0f);
      wr(OFS_DATA, 8'hf0);
      wr(OFS_CSB, 8'h60);
      rd(OFS_CSA, 8'h00, "csa busy");
      `CHK("empty irq off", 1'b0, ie)
      `CHK("oe held", 1'b1, oe)
      `WAITC(!oe, 600)
      `CHK("last frame", 10'h3f0, got)
      cyc(3);
      `CHK("txc set", 1'b1, ic)
      pulse_ack();
      wr(OFS_FMT, 8'h0e);
      wr(OFS_CSB, 8'h4d);
      wr(OFS_DATA, 8'h3c);
      `WAITC(ic, 400)
      `CHK("nine bit frame", 10'h33c, got)
      pulse_ack();
   endtask
   task automatic t_rx;
      wr(OFS_FMT, 8'h06);
      wr(OFS_CSB, 8'h90);
      cyc(2);
      `CHK("rx pin", 1'b1, rxo)
      for (int i = 1; i < 5; i++) rem.send({3'h0, 8'h11 * i[7:0]}, 8);
      cyc(1);
      `CHK("rx irq", 1'b1, ir)
      rd(OFS_CSA, 8'ha0, "csa rx");
      for (int i = 1; i < 3; i++) rd(OFS_DATA, 8'h11 * i[7:0], "order");
      rd(OFS_CSA, 8'ha8, "overrun");
      rd(OFS_DATA, 8'h44, "after loss");
      cyc(2);
      rd(OFS_CSA, 8'h20, "csa empty");
      `CHK("rx irq off", 1'b0, ir)
      wr(OFS_FMT, 8'h00);
      rem.send(11'h7ff, 5);
      rd(OFS_DATA, 8'h1f, "short char");
      wr(OFS_FMT, 8'h06);
      wr(OFS_CSB, 8'h94);
      rem.send(11'h1c3, 9);
      rd(OFS_CSB, 8'h96, "ninth bit");
      rd(OFS_DATA, 8'hc3, "ninth low");
      rem.send(11'h055, 9);
      wr(OFS_CSB, 8'h00);
      cyc(5);
      `CHK("rx irq flush", 1'b0, ir)
      rd(OFS_CSA, 8'h20, "csa flush");
      wr(OFS_FMT, 8'h46);
      wr(OFS_CSB, 8'h90);
      rem.ssend(8'h96);
      rd(OFS_DATA, 8'h96, "sync rx");
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_tx();
      t_rx();
      finish_test();
   end
endmodule
bind ubfl_core ubfl_core_asserts chk (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .ADDR_IN(ADDR_IN),
   .WR_DATA_IN(WR_DATA_IN), .WR_EN_IN(WR_EN_IN), .RD_EN_IN(RD_EN_IN),
   .SERIAL_IN_PIN_IN(SERIAL_IN_PIN_IN), .EXT_XFER_CLK_PIN_IN(EXT_XFER_CLK_PIN_IN),
   .TX_COMPLETE_ACK_IN(TX_COMPLETE_ACK_IN), .RD_DATA_OUT(RD_DATA_OUT),
   .SERIAL_OUT_PIN_OUT(SERIAL_OUT_PIN_OUT), .SERIAL_OUT_OE_OUT(SERIAL_OUT_OE_OUT),
   .RX_PIN_OVERRIDE_OUT(RX_PIN_OVERRIDE_OUT), .TX_BUF_EMPTY_IRQ_OUT(TX_BUF_EMPTY_IRQ_OUT),
   .TX_COMPLETE_IRQ_OUT(TX_COMPLETE_IRQ_OUT), .RX_COMPLETE_IRQ_OUT(RX_COMPLETE_IRQ_OUT));
`default_nettype wire
